// file: src/vtm_top.v
/*
 * VLAN membership, egress tagging and port mirroring decisions for a
 * four-port switch, with an APB register slave.
 * Assumes one descriptor per frame from the forwarding engine, inputs
 * synchronous to clk, and a mirror target that shows readiness each cycle.
 */
// The register addresses and the APB register port were chosen for this implementation.
module vtm_top
(
   input wire clk,
   input wire nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire frm_valid,
   input wire [1:0] frm_src,
   input wire frm_tagged,
   input wire [11:0] frm_vid,
   input wire frm_gvrp,
   input wire [3:0] frm_dst_mask,
   input wire [3:0] port_fast,
   input wire mir_ready,
   output reg dec_valid,
   output reg dec_drop,
   output reg [3:0] dec_fwd_mask,
   output reg [7:0] dec_tag_op,
   output reg [47:0] dec_ins_vid,
   output reg dec_mirror,
   output reg [1:0] dec_tgt,
   output reg gvrp_en
);

`include "vtm_regs.vh"

   localparam NP = 4;
   localparam NE = 8;

   reg [1:0] tgt_q;
   reg [7:0] mir_mode_q;
   reg [2:0] ent_sel_q;
   reg [5:0] name_sel_q;
   reg [3:0] err_q;
   reg [15:0] drop_cnt_q;
   reg [11:0] pvid_q [0:NP-1];
   reg [NE-1:0] ent_valid_q;
   reg [NE-1:0] ent_pbv_q;
   reg [NE-1:0] ent_lock_q;
   reg [11:0] ent_vid_q [0:NE-1];
   reg [7:0] ent_memb_q [0:NE-1];

   wire setup_ph;
   wire wr_en;
   wire [31:0] name_rdata;
   wire name_we;
   reg [31:0] rd_d;
   reg rd_err_d;
   reg wr_err_d;
   reg [3:0] err_set;
   reg busy;
   integer i;
   integer k;
   integer p;

   assign setup_ph = psel & ~penable;
   assign wr_en = psel & penable & pwrite & pready;

   // names may only be written while the entry is not yet created
   assign name_we = wr_en & (paddr == `VTM_A_NAME_DATA) &
                    ~ent_lock_q[name_sel_q[5:3]];

   vtm_name_mem #(.AW(6), .DW(32)) u_name
   (
      .clk(clk),
      .we(name_we),
      .waddr(name_sel_q),
      .wdata(pwdata),
      .raddr(name_sel_q),
      .rdata(name_rdata)
   );

   // read mux, evaluated in the setup phase so prdata can be a flop
   always @*
   begin
      rd_d = 32'h0;
      rd_err_d = 1'b0;
      if (paddr == `VTM_A_CTRL)
      begin
         rd_d[`VTM_F_GVRP] = gvrp_en;
         rd_d[`VTM_F_TGT_LO+1:`VTM_F_TGT_LO] = tgt_q;
      end
      else if (paddr == `VTM_A_MIRROR)
         rd_d[7:0] = mir_mode_q;
      else if (paddr == `VTM_A_ENT_SEL)
         rd_d[2:0] = ent_sel_q;
      else if (paddr == `VTM_A_ENT_VID)
      begin
         rd_d[11:0] = ent_vid_q[ent_sel_q];
         rd_d[`VTM_F_PBV] = ent_pbv_q[ent_sel_q];
         rd_d[`VTM_F_LOCK] = ent_lock_q[ent_sel_q];
         rd_d[`VTM_F_VALID] = ent_valid_q[ent_sel_q];
      end
      else if (paddr == `VTM_A_ENT_MEMB)
         rd_d[7:0] = ent_memb_q[ent_sel_q];
      else if (paddr == `VTM_A_ENT_DEL)
         rd_d = 32'h0;
      else if (paddr == `VTM_A_NAME_SEL)
         rd_d[5:0] = name_sel_q;
      else if (paddr == `VTM_A_NAME_DATA)
         rd_d = name_rdata;
      else if (paddr == `VTM_A_STATUS)
         rd_d[3:0] = err_q;
      else if (paddr == `VTM_A_MIR_DROP)
         rd_d[15:0] = drop_cnt_q;
      else if (paddr[7:4] == 4'h2 || paddr[7:4] == 4'h3)
      begin
         if (paddr >= `VTM_A_PVID0 && paddr[1:0] == 2'h0 &&
             paddr < (`VTM_A_PVID0 + 8'h10))
            rd_d[11:0] = pvid_q[paddr[3:2] - 2'h2];
         else
            rd_err_d = 1'b1;
      end
      else
         rd_err_d = 1'b1;
   end

   // write checks: range, name lock, port-based exclusivity, default entry
   always @*
   begin
      err_set = 4'h0;
      busy = 1'b0;
      for (p = 0; p < NP; p = p + 1)
         for (k = 0; k < NE; k = k + 1)
            if (k != ent_sel_q && ent_valid_q[k] &&
                pwdata[2*p +: 2] != `VTM_M_NONE &&
                ent_memb_q[k][2*p +: 2] != `VTM_M_NONE)
               busy = 1'b1;
      if (wr_en && paddr == `VTM_A_ENT_VID)
      begin
         if (pwdata[11:0] < `VTM_VID_MIN || pwdata[11:0] > `VTM_VID_MAX)
            err_set[`VTM_E_RANGE] = 1'b1;
         if (ent_lock_q[ent_sel_q])
            err_set[`VTM_E_LOCKED] = 1'b1;
      end
      if (wr_en && paddr == `VTM_A_ENT_MEMB && ent_pbv_q[ent_sel_q] &&
          busy)
         err_set[`VTM_E_BUSY] = 1'b1;
      if (wr_en && paddr == `VTM_A_ENT_DEL && ent_sel_q == 3'h0)
         err_set[`VTM_E_DEFAULT] = 1'b1;
      if (wr_en && paddr == `VTM_A_NAME_DATA &&
          ent_lock_q[name_sel_q[5:3]])
         err_set[`VTM_E_LOCKED] = 1'b1;
      wr_err_d = |err_set;
   end

   // apb slave: one wait-free access, answer registered from setup phase
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= setup_ph;
         pslverr <= setup_ph & rd_err_d;
         if (setup_ph && !pwrite)
            prdata <= rd_d;
      end
   end

   // configuration registers and vlan table
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         gvrp_en <= 1'b0;
         tgt_q <= `VTM_RST_TGT;
         mir_mode_q <= 8'h00;
         ent_sel_q <= 3'h0;
         name_sel_q <= 6'h00;
         err_q <= 4'h0;
         ent_valid_q <= 8'h01;
         ent_pbv_q <= 8'h00;
         ent_lock_q <= 8'h01;
         for (i = 0; i < NE; i = i + 1)
         begin
            ent_vid_q[i] <= (i == 0) ? `VTM_VID_DEF : 12'h000;
            ent_memb_q[i] <= (i == 0) ? `VTM_RST_MEMB : 8'h00;
         end
         for (i = 0; i < NP; i = i + 1)
            pvid_q[i] <= `VTM_VID_DEF;
      end
      else
      begin
         // write-one-to-clear; a new error in the same cycle wins
         if (wr_en && paddr == `VTM_A_STATUS)
            err_q <= (err_q & ~pwdata[3:0]) | err_set;
         else
            err_q <= err_q | err_set;
         if (wr_en && paddr == `VTM_A_CTRL)
         begin
            gvrp_en <= pwdata[`VTM_F_GVRP];
            tgt_q <= pwdata[`VTM_F_TGT_LO+1:`VTM_F_TGT_LO];
         end
         if (wr_en && paddr == `VTM_A_MIRROR)
            mir_mode_q <= pwdata[7:0];
         if (wr_en && paddr == `VTM_A_ENT_SEL)
            ent_sel_q <= pwdata[2:0];
         if (wr_en && paddr == `VTM_A_NAME_SEL)
            name_sel_q <= pwdata[5:0];
         // create: entry locked, name frozen from here on
         if (wr_en && paddr == `VTM_A_ENT_VID && !wr_err_d)
         begin
            ent_vid_q[ent_sel_q] <= pwdata[11:0];
            ent_pbv_q[ent_sel_q] <= pwdata[`VTM_F_PBV];
            ent_valid_q[ent_sel_q] <= 1'b1;
            ent_lock_q[ent_sel_q] <= 1'b1;
            ent_memb_q[ent_sel_q] <= 8'h00;
         end
         if (wr_en && paddr == `VTM_A_ENT_MEMB && !wr_err_d &&
             ent_valid_q[ent_sel_q])
            ent_memb_q[ent_sel_q] <= pwdata[7:0];
         // the default entry survives; only its members can move
         if (wr_en && paddr == `VTM_A_ENT_DEL && !wr_err_d)
         begin
            ent_valid_q[ent_sel_q] <= 1'b0;
            ent_lock_q[ent_sel_q] <= 1'b0;
            ent_memb_q[ent_sel_q] <= 8'h00;
         end
         for (i = 0; i < NP; i = i + 1)
            if (wr_en && paddr == (`VTM_A_PVID0 + 4 * i))
               pvid_q[i] <= pwdata[11:0];
      end
   end

   // frame classification: resolve vlan, then the entry it hits
   reg [11:0] fvid;
   reg hit;
   reg [2:0] hidx;
   reg [7:0] memb;
   reg [1:0] src_code;
   reg drop;
   reg [3:0] want_mask;
   integer fk;
   always @*
   begin
      fvid = frm_tagged ? frm_vid : pvid_q[frm_src];
      hit = 1'b0;
      hidx = 3'h0;
      for (fk = NE - 1; fk >= 0; fk = fk - 1)
         if (ent_valid_q[fk] && ent_vid_q[fk] == fvid)
         begin
            hit = 1'b1;
            hidx = fk[2:0];
         end
      memb = hit ? ent_memb_q[hidx] : 8'h00;
      src_code = memb[2*frm_src +: 2];
      // unknown vlan is dropped too: nobody can be a member of it
      drop = ~hit | (frm_tagged & (src_code == `VTM_M_FORBID)) |
             (frm_gvrp & ~gvrp_en);
      want_mask = drop ? 4'h0 : frm_dst_mask;
      want_mask[frm_src] = 1'b0;
   end

   wire [3:0] fwd;
   wire [7:0] tag_op;
   genvar g;
   generate
      for (g = 0; g < NP; g = g + 1)
      begin : g_eg
         vtm_egress u_eg
         (
            .code(memb[2*g +: 2]),
            .frm_tagged(frm_tagged),
            .want(want_mask[g]),
            .fwd(fwd[g]),
            .tag_op(tag_op[2*g +: 2])
         );
      end
   endgenerate

   // mirror selection; the forwarding mask is left exactly as computed
   reg mir_want;
   reg mir_slow;
   reg mir_copy;
   integer mp;
   always @*
   begin
      mir_want = mir_mode_q[2*frm_src];
      for (mp = 0; mp < NP; mp = mp + 1)
         if (fwd[mp] && mir_mode_q[2*mp+1])
            mir_want = 1'b1;
      // a slower target cannot keep up; the copy is lost, not queued
      mir_slow = ~port_fast[tgt_q] & port_fast[frm_src];
      mir_copy = frm_valid & mir_want & ~mir_slow & mir_ready;
   end

   // decision outputs, one cycle after the descriptor
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         dec_valid <= 1'b0;
         dec_drop <= 1'b0;
         dec_fwd_mask <= 4'h0;
         dec_tag_op <= 8'h00;
         dec_ins_vid <= 48'h0;
         dec_mirror <= 1'b0;
         dec_tgt <= `VTM_RST_TGT;
         drop_cnt_q <= 16'h0000;
      end
      else
      begin
         dec_valid <= frm_valid;
         dec_drop <= frm_valid & drop;
         dec_fwd_mask <= frm_valid ? fwd : 4'h0;
         dec_tag_op <= frm_valid ? tag_op : 8'h00;
         dec_ins_vid <= {pvid_q[3], pvid_q[2], pvid_q[1], pvid_q[0]};
         dec_mirror <= mir_copy;
         dec_tgt <= tgt_q;
         // saturating count of copies lost to the target
         if (frm_valid && mir_want && !mir_copy && drop_cnt_q != 16'hFFFF)
            drop_cnt_q <= drop_cnt_q + 16'h0001;
      end
   end

endmodule

// file: src/vtm_regs.vh
/*
 * Register offsets, field positions, codes and reset values shared by the
 * VLAN tag and port mirror block.
 * Assumes inclusion by bare name from the design files under src/.
 */
`ifndef VTM_REGS_VH
`define VTM_REGS_VH

// apb byte offsets
`define VTM_A_CTRL      8'h00
`define VTM_A_MIRROR    8'h04
`define VTM_A_ENT_SEL   8'h08
`define VTM_A_ENT_VID   8'h0C
`define VTM_A_ENT_MEMB  8'h10
`define VTM_A_ENT_DEL   8'h14
`define VTM_A_NAME_SEL  8'h18
`define VTM_A_NAME_DATA 8'h1C
`define VTM_A_STATUS    8'h20
`define VTM_A_MIR_DROP  8'h24
`define VTM_A_PVID0     8'h28

// field positions
`define VTM_F_GVRP      0
`define VTM_F_TGT_LO    4
`define VTM_F_PBV       16
`define VTM_F_LOCK      17
`define VTM_F_VALID     18

// membership codes, two bits per port
`define VTM_M_NONE      2'h0
`define VTM_M_UNTAG     2'h1
`define VTM_M_TAG       2'h2
`define VTM_M_FORBID    2'h3

// mirror modes, bit 0 receive, bit 1 transmit
`define VTM_MIR_NONE    2'h0
`define VTM_MIR_RX      2'h1
`define VTM_MIR_TX      2'h2
`define VTM_MIR_BOTH    2'h3

// egress tag operations
`define VTM_OP_KEEP     2'h0
`define VTM_OP_STRIP    2'h1
`define VTM_OP_INSERT   2'h2

// vlan identifier limits for user entries
`define VTM_VID_MIN     12'h002
`define VTM_VID_MAX     12'hFFE
`define VTM_VID_DEF     12'h001

// reset values
`define VTM_RST_MEMB    8'h55
`define VTM_RST_TGT     2'h0

// status error bits
`define VTM_E_RANGE     0
`define VTM_E_LOCKED    1
`define VTM_E_BUSY      2
`define VTM_E_DEFAULT   3

`endif

// file: src/vtm_name_mem.v
/*
 * Small name store: one write port, one read port, read data registered.
 * Assumes a single clock; contents are not reset, software writes names
 * before it creates the entry that owns them.
 */
module vtm_name_mem
#(
   parameter AW = 6,
   parameter DW = 32
)
(
   input wire clk,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   input wire [AW-1:0] raddr,
   output reg [DW-1:0] rdata
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   // write and registered read share the edge; read shows old data on a hit
   always @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule

// file: src/vtm_egress.v
/*
 * Per-port egress decision: forwarding and tag operation for one port.
 * Assumes the caller has already resolved the frame's vlan entry.
 */
module vtm_egress
(
   input wire [1:0] code,
   input wire frm_tagged,
   input wire want,
   output reg fwd,
   output reg [1:0] tag_op
);

`include "vtm_regs.vh"

   // only members of the frame's vlan see it on egress
   always @*
   begin
      fwd = want & ((code == `VTM_M_UNTAG) | (code == `VTM_M_TAG));
      tag_op = `VTM_OP_KEEP;
      if (code == `VTM_M_UNTAG && frm_tagged)
      begin
         tag_op = `VTM_OP_STRIP;
      end
      else if (code == `VTM_M_TAG && !frm_tagged)
      begin
         tag_op = `VTM_OP_INSERT;
      end
      // a tagged frame on a tagged port leaves untouched
      if (!fwd)
      begin
         tag_op = `VTM_OP_KEEP;
      end
   end

endmodule

// file: tb/vtm_top_assertions.sv
/*
 * Port checker for vtm_top: apb answer timing, decision timing and masks,
 * gvrp filtering and mirror drop conditions.
 * Assumes it is bound onto vtm_top and sees only that block's ports.
 */
module vtm_chk
(
   input wire clk,
   input wire nrst,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire frm_valid,
   input wire [1:0] frm_src,
   input wire frm_gvrp,
   input wire [3:0] frm_dst_mask,
   input wire [3:0] port_fast,
   input wire mir_ready,
   input wire dec_valid,
   input wire dec_drop,
   input wire [3:0] dec_fwd_mask,
   input wire dec_mirror,
   input wire [1:0] dec_tgt,
   input wire gvrp_en
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   // zero wait states: access cycle always answered
   AST_APB_ANS: assert property (psel && !penable |=> pready && penable)
      else $error("pready missing in access cycle");
   AST_DEC_LAT: assert property (frm_valid |=> dec_valid)
      else $error("decision not one cycle after frame");
   AST_NO_SRC: assert property (
      frm_valid |=> (dec_fwd_mask & (4'h1 << $past(frm_src))) == 4'h0)
      else $error("frame sent back to its source");
   AST_SUBSET: assert property (
      frm_valid |=> (dec_fwd_mask & ~$past(frm_dst_mask)) == 4'h0)
      else $error("forward mask widened");
   AST_DROP: assert property (dec_drop |-> dec_fwd_mask == 4'h0)
      else $error("dropped frame still forwarded");
   AST_GVRP: assert property (
      frm_valid && frm_gvrp && !gvrp_en |=> dec_valid && dec_drop)
      else $error("gvrp frame passed while disabled");
   AST_RST: assert property ($rose(nrst) |-> !gvrp_en && !dec_valid)
      else $error("gvrp flag set out of reset");
   AST_BUSY: assert property (frm_valid && !mir_ready |=> !dec_mirror)
      else $error("copy sent to busy target");
   AST_SLOW: assert property (
      frm_valid && port_fast[frm_src] && !port_fast[dec_tgt]
      ##1 $stable(dec_tgt) |-> !dec_mirror)
      else $error("copy sent to slower target");
endmodule

// file: tb/vtm_partner.sv
/*
 * Link partners and analyzer: port speeds, target readiness, copy count.
 * Assumes one clock; slow makes the analyzer refuse about half the time.
 */
module vtm_link
(
   input wire clk,
   input wire nrst,
   input wire slow,
   input wire dec_mirror,
   output reg mir_ready,
   output reg [3:0] port_fast,
   output int n_copy
);
   timeunit 1ns;
   timeprecision 100ps;

   // speeds move now and then so slow targets meet fast sources
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         mir_ready <= 1'b1;
         port_fast <= 4'hF;
         n_copy <= 0;
      end
      else
      begin
         mir_ready <= slow ? 1'($urandom % 2) : 1'b1;
         if ($urandom % 16 == 0)
            port_fast <= 4'($urandom);
         if (dec_mirror)
            n_copy <= n_copy + 1;
      end
   end
endmodule

// file: tb/tb.sv
/*
 * Self-checking bench for vtm_top: apb setup, random frames, model compare.
 * Assumes vtm_regs.vh on the include path.
 */
`include "vtm_regs.vh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic d; logic [3:0] f; logic [7:0] t; logic m;} vtm_x_t;
   logic clk, nrst, psel, penable, pwrite, frm_valid, frm_tagged, frm_gvrp;
   logic slow, pready, pslverr, mir_ready, dec_valid, dec_drop, dec_mirror;
   logic gvrp_en;
   logic [7:0] paddr, dec_tag_op;
   logic [31:0] pwdata, prdata;
   logic [1:0] frm_src, dec_tgt;
   logic [11:0] frm_vid;
   logic [3:0] frm_dst_mask, port_fast, dec_fwd_mask;
   logic [47:0] dec_ins_vid;
   int n_mismatch, total_checks, n_copy, e_drop, e_cp, gv, tgt;
   int ent_vid[8], memb[8], pvid[4], mode[4], vt[5], vs[5];
   bit ent_ok[8];
   vtm_x_t q[$];

   vtm_top vtm_top_inst (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .frm_valid, .frm_src, .frm_tagged,
      .frm_vid, .frm_gvrp, .frm_dst_mask, .port_fast, .mir_ready, .dec_valid,
      .dec_drop, .dec_fwd_mask, .dec_tag_op, .dec_ins_vid, .dec_mirror,
      .dec_tgt, .gvrp_en);
   vtm_link vtm_link_inst (.clk, .nrst, .slow, .dec_mirror, .mir_ready,
      .port_fast, .n_copy);

   always #5 clk = ~clk;

   task chk(input string n, input logic [47:0] x, input logic [47:0] g);
      total_checks++;
      if (g !== x)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %0h got %0h", n, x, g);
      end
   endtask

   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // one apb transfer; request held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic er);
      int k;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      r = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      if (pready !== 1'b1)
      begin
         n_mismatch++;
         report_and_stop();
      end
      // idle edge, so a following call never re-drives psel in this step
      @(posedge clk);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic er;
      apb(1, a, d, r, er);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] x, input string n);
      logic [31:0] r;
      logic er;
      apb(0, a, 0, r, er);
      chk(n, x, r);
   endtask

   // random descriptors, back to back with gaps
   task rnd(input int n);
      repeat (n)
      begin
         frm_valid <= $urandom % 4 != 0;
         frm_src <= 2'($urandom);
         frm_tagged <= 1'($urandom);
         frm_vid <= 12'(vs[$urandom % 5]);
         frm_gvrp <= $urandom % 8 == 0;
         frm_dst_mask <= 4'($urandom);
         @(posedge clk);
      end
      frm_valid <= 0;
      @(posedge clk);
   endtask

   // reference decision, taken from the inputs sampled at the frame edge
   always @(posedge clk)
      if (nrst && frm_valid)
      begin : mdl
         int v, e, c, w;
         vtm_x_t x;
         v = frm_tagged ? frm_vid : pvid[frm_src];
         e = -1;
         for (int i = 0; i < 8; i++)
            if (ent_ok[i] && ent_vid[i] == v)
               e = i;
         c = (e < 0) ? 0 : memb[e];
         x.d = e < 0 || (frm_tagged && c[2*frm_src+:2] == 3)
            || (frm_gvrp && !gv);
         w = mode[frm_src] & 1;
         for (int p = 0; p < 4; p++)
         begin
            x.f[p] = frm_dst_mask[p] && !x.d && p != frm_src
               && c[2*p+:2] inside {1, 2};
            x.t[2*p+:2] = !x.f[p] ? 0 : (c[2*p+:2] == 1 && frm_tagged) ? 1
               : (c[2*p+:2] == 2 && !frm_tagged) ? 2 : 0;
            if (x.f[p] && mode[p][1])
               w = 1;
         end
         x.m = w && mir_ready && !(!port_fast[tgt] && port_fast[frm_src]);
         e_cp += x.m;
         if (w && !x.m && e_drop < 'hFFFF)
            e_drop++;
         q.push_back(x);
      end

   // compare settled outputs mid-cycle, one cycle after each frame
   always @(negedge clk)
      if (nrst && (dec_valid !== 1'b0 || q.size() > 0))
      begin : cmp
         vtm_x_t x;
         chk("dec_valid", q.size() > 0, dec_valid);
         if (q.size() > 0)
         begin
            x = q.pop_front();
            chk("dec_drop", x.d, dec_drop);
            chk("dec_fwd_mask", x.f, dec_fwd_mask);
            chk("dec_tag_op", x.t, dec_tag_op);
            chk("dec_mirror", x.m, dec_mirror);
            chk("dec_tgt", tgt, dec_tgt);
            chk("gvrp_en", gv, gvrp_en);
            chk("dec_ins_vid", {12'(pvid[3]), 12'(pvid[2]), 12'(pvid[1]),
               12'(pvid[0])}, dec_ins_vid);
         end
      end

   initial
   begin : main
      logic [31:0] r;
      logic er;
      {clk, nrst, psel, penable, pwrite, paddr, pwdata, slow} = 0;
      {frm_valid, frm_src, frm_tagged, frm_vid, frm_gvrp, frm_dst_mask} = 0;
      ent_ok = '{1, 0, 0, 0, 0, 0, 0, 0};
      ent_vid = '{1, 0, 0, 0, 0, 0, 0, 0};
      memb = '{'h55, 0, 0, 0, 0, 0, 0, 0};
      pvid = '{1, 1, 1, 1};
      mode = '{0, 0, 0, 0};
      vt = '{0, 1, 4095, 2, 4094};
      vs = '{1, 2, 4094, 100, 7};
      void'($urandom(55495));
      repeat (6) @(posedge clk);
      nrst <= 1;
      @(posedge clk);
      rd(`VTM_A_CTRL, 0, "ctrl");
      rd(`VTM_A_ENT_VID, 'h60001, "ent_vid");
      rd(`VTM_A_ENT_MEMB, 'h55, "ent_memb");
      rd(`VTM_A_PVID0, 1, "pvid0");
      apb(0, 8'hFC, 0, r, er);
      chk("pslverr", 1, er);
      wr(`VTM_A_ENT_DEL, 0);
      rd(`VTM_A_STATUS, 8, "status");
      wr(`VTM_A_STATUS, 'hF);
      rd(`VTM_A_ENT_VID, 'h60001, "ent_vid");
      for (int i = 0; i < 5; i++)
      begin
         wr(`VTM_A_ENT_SEL, i + 1);
         wr(`VTM_A_ENT_VID, vt[i]);
         ent_ok[i+1] = vt[i] >= 2 && vt[i] <= 4094;
         ent_vid[i+1] = vt[i];
         rd(`VTM_A_STATUS, !ent_ok[i+1], "status");
         wr(`VTM_A_STATUS, 'hF);
      end
      wr(`VTM_A_ENT_VID, 3);
      rd(`VTM_A_STATUS, 2, "status");
      // port 3 stays free here so the port-based entry can claim it
      wr(`VTM_A_ENT_MEMB, 'h2A);
      memb[5] = 'h2A;
      wr(`VTM_A_ENT_SEL, 4);
      wr(`VTM_A_ENT_MEMB, 'h39);
      memb[4] = 'h39;
      wr(`VTM_A_NAME_SEL, 'h30);
      wr(`VTM_A_NAME_DATA, 'h61626364);
      wr(`VTM_A_ENT_SEL, 6);
      wr(`VTM_A_ENT_VID, 'h10064);
      {ent_ok[6], ent_vid[6]} = {1'b1, 32'd100};
      wr(`VTM_A_NAME_DATA, 'h31323334);
      rd(`VTM_A_NAME_DATA, 'h61626364, "name");
      wr(`VTM_A_STATUS, 'hF);
      wr(`VTM_A_ENT_MEMB, 'h40);
      rd(`VTM_A_STATUS, 4, "status");
      wr(`VTM_A_ENT_SEL, 0);
      wr(`VTM_A_ENT_MEMB, 'h15);
      memb[0] = 'h15;
      wr(`VTM_A_ENT_SEL, 6);
      wr(`VTM_A_STATUS, 'hF);
      wr(`VTM_A_ENT_MEMB, 'h40);
      memb[6] = 'h40;
      rd(`VTM_A_STATUS, 0, "status");
      wr(`VTM_A_PVID0 + 4, 2);
      wr(`VTM_A_PVID0 + 12, 100);
      // untagged frames from port 2 reach tagged members: tag inserted
      wr(`VTM_A_PVID0 + 8, 4094);
      pvid = '{1, 2, 4094, 100};
      // three mirrored ports keep the advisory limit
      wr(`VTM_A_MIRROR, 'h39);
      mode = '{1, 2, 3, 0};
      wr(`VTM_A_CTRL, 'h30);
      tgt = 3;
      rnd(300);
      slow <= 1;
      rnd(300);
      wr(`VTM_A_CTRL, 'h31);
      gv = 1;
      rnd(300);
      rd(`VTM_A_MIR_DROP, e_drop, "mir_drop");
      chk("copies", e_cp, n_copy);
      report_and_stop();
   end
endmodule

bind vtm_top vtm_chk vtm_chk_inst (.clk, .nrst, .psel, .penable, .pready,
   .frm_valid, .frm_src, .frm_gvrp, .frm_dst_mask, .port_fast, .mir_ready,
   .dec_valid, .dec_drop, .dec_fwd_mask, .dec_mirror, .dec_tgt, .gvrp_en);
